/* File: eal_defines.svh */
`ifndef EAL_DEFINES_SVH
`define EAL_DEFINES_SVH
`define EAL_CLK_HZ 25000000
`define EAL_MS_PER_S 1000
`define EAL_LOG_RECS 20
`define EAL_REC_WORDS 5
`define EAL_LOG_WORDS 100
`define EAL_A_CODE 8'h00
`define EAL_A_PTR 8'h01
`define EAL_A_CTRL 8'h02
`define EAL_A_STAT 8'h03
`define EAL_A_MONTIME 8'h04
`define EAL_A_FPDCFG 8'h05
`define EAL_A_DIAGADDR 8'h06
`define EAL_A_INDEX 8'h07
`define EAL_A_MSG 8'h08
`define EAL_A_PRESET0 8'h0e
`define EAL_A_PRESET1 8'h0f
`define EAL_A_TIME_LO 8'h10
`define EAL_A_TIME_HI 8'h11
`define EAL_A_FLAGS 3'b001
`define EAL_CTRL_KILL 0
`define EAL_CTRL_RETAIN 1
`define EAL_CTRL_TEACH 2
`define EAL_CTRL_PTRRST 3
`define EAL_CTRL_ERRCLR 4
`define EAL_CFG_ALARM 0
`define EAL_CFG_ASCII 1
`define EAL_CFG_INDEX 2
`define EAL_CFG_PREFIX 3
`define EAL_MONTIME_RST 16'h2710
`endif

/* File: eal_pkg.sv */
package eal_pkg;
  typedef enum logic [2:0] {
    EAL_FPD_IDLE = 3'b001,
    EAL_FPD_TIME = 3'b010,
    EAL_FPD_FAIL = 3'b100
  } eal_fpd_state_t;
  typedef enum logic [1:0] {
    EAL_MODE_PROGRAM = 2'h0,
    EAL_MODE_MONITOR = 2'h1,
    EAL_MODE_RUN = 2'h2
  } eal_mode_t;
endpackage

/* File: eal_top.sv */
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "eal_defines.svh"
module eal_top #(
  parameter int TICK_CYCLES = `EAL_CLK_HZ / 1000,
  parameter logic [15:0] NONFATAL_CODE_BASE = 16'h1000, // Arbitrary value.
  parameter logic [15:0] FATAL_CODE_BASE = 16'h2000 // Arbitrary value.
) (
  input wire logic sys_clk, // Clock, 25 MHz.
  input wire logic resetn, // Asynchronous reset.
  input wire logic [7:0] reg_addr, // Register word address.
  input wire logic [15:0] reg_wdata, // Write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  output logic [15:0] reg_rdata, // Read data, cycle after the strobe.
  input wire logic [1:0] op_mode, // Operating mode.
  input wire logic sys_err_stb, // System error detected.
  input wire logic [15:0] sys_err_code, // System error code.
  input wire logic [15:0] sys_err_detail, // System error details.
  input wire logic nonfatal_alarm_instr, // Nonfatal alarm executed.
  input wire logic fatal_alarm_instr, // Fatal alarm executed.
  input wire logic [8:0] alarm_num, // Alarm number of either instruction.
  input wire logic failure_point_detector, // Detector executed.
  input wire logic diag_output, // Monitored diagnostic output.
  input wire logic [15:0] diag_inputs, // Inputs of the diagnosed block.
  input wire logic [15:0] diag_in_base, // Bit address of diag_inputs[0].
  output logic outputs_off, // All output units forced off.
  output logic program_halt, // Program execution stopped.
  output logic error_led, // Front error indicator.
  output logic carry_flag, // Detector timeout.
  output logic [15:0] index_reg // Index register load value.
);
  localparam logic [4:0] LOG_RECS = 5'(`EAL_LOG_RECS);

  function automatic logic [3:0] first_zero(input logic [15:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (!v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] hex_ascii(input logic [3:0] n);
    return (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction

  logic [15:0] log_mem [0:`EAL_LOG_WORDS-1];
  logic [15:0] flag_mem [0:31];
  logic [4:0] ptr_reg, ptr_next;
  logic [15:0] code_reg, rdata_reg, rdata_next;
  logic kill_reg, retain_reg, teach_reg;
  logic nf_flag_reg, fatal_flag_reg, halt_reg, off_reg, led_reg;
  logic [15:0] mon_time_reg, fpd_cfg_reg, diag_addr_reg, index_q_reg;
  logic [15:0] msg_reg [0:3];
  logic [15:0] preset_reg [0:1];
  logic [14:0] tick_cnt_reg;
  logic [9:0] ms_cnt_reg;
  logic [31:0] seconds_reg;
  logic blink_reg, carry_reg;
  logic [15:0] fpd_cnt_reg;
  eal_pkg::eal_fpd_state_t fpd_state_reg, fpd_state_next;

  // Register decode.
  wire ctrl_wr = reg_wr && reg_addr == `EAL_A_CTRL;
  wire ptr_reset = ctrl_wr && reg_wdata[`EAL_CTRL_PTRRST];
  wire err_clear = ctrl_wr && reg_wdata[`EAL_CTRL_ERRCLR];
  wire mon_wr = reg_wr && reg_addr == `EAL_A_MONTIME;
  wire ms_tick = tick_cnt_reg == 15'(TICK_CYCLES - 1);
  wire s_tick = ms_tick && ms_cnt_reg == 10'(`EAL_MS_PER_S - 1);

  // Failure point detector.
  wire fpd_timing = fpd_state_reg == eal_pkg::EAL_FPD_TIME;
  wire fpd_done = fpd_timing && diag_output;
  wire fpd_timeout = fpd_timing && !diag_output && fpd_cnt_reg >= mon_time_reg;
  wire [3:0] blk_idx = first_zero(diag_inputs);
  wire [15:0] blk_addr = diag_in_base + {12'h000, blk_idx};
  wire [31:0] blk_ascii = {hex_ascii(blk_addr[15:12]), hex_ascii(blk_addr[11:8]),
                           hex_ascii(blk_addr[7:4]), hex_ascii(blk_addr[3:0])};
  wire fpd_alarm = fpd_timeout && fpd_cfg_reg[`EAL_CFG_ALARM];
  wire cfg_ascii = fpd_cfg_reg[`EAL_CFG_ASCII];

  // Event selection; a fatal alarm takes the single log slot of a cycle first.
  wire nf_clear = nonfatal_alarm_instr && alarm_num == 9'h000;
  wire nf_user = nonfatal_alarm_instr && alarm_num != 9'h000;
  wire nf_raise = nf_user || fpd_alarm;
  wire [8:0] nf_num = nf_user ? alarm_num : fpd_cfg_reg[12:4];
  wire alarm_any = fatal_alarm_instr || nf_raise;
  wire [8:0] ev_num = fatal_alarm_instr ? alarm_num : nf_num;
  wire log_wr = alarm_any || sys_err_stb;
  wire [15:0] ev_code = fatal_alarm_instr ? FATAL_CODE_BASE + {7'h00, alarm_num} :
                        nf_raise ? NONFATAL_CODE_BASE + {7'h00, nf_num} : sys_err_code;
  wire [15:0] ev_detail = alarm_any ? {7'h00, ev_num} : sys_err_detail;

  // Log placement: pointer reset in the same cycle puts the record in slot 0.
  wire [4:0] ptr_eff = ptr_reset ? 5'h00 : ptr_reg;
  wire log_full = ptr_eff >= LOG_RECS;
  wire [4:0] slot = log_full ? LOG_RECS - 5'h01 : ptr_eff;
  wire [6:0] wbase = {slot, 2'b00} + {2'b00, slot};

  // Read decode.
  wire in_log = reg_addr[7] && reg_addr[6:0] < 7'(`EAL_LOG_WORDS);
  wire in_flags = reg_addr[7:5] == `EAL_A_FLAGS;
  logic [15:0] misc_word;
  always_comb begin
    case (reg_addr)
      `EAL_A_CODE: misc_word = code_reg;
      `EAL_A_PTR: misc_word = {11'h000, ptr_reg};
      `EAL_A_CTRL: misc_word = {13'h0000, teach_reg, retain_reg, kill_reg};
      `EAL_A_STAT: misc_word = {11'h000, fpd_timing, halt_reg, carry_reg,
                                fatal_flag_reg, nf_flag_reg};
      `EAL_A_MONTIME: misc_word = mon_time_reg;
      `EAL_A_FPDCFG: misc_word = fpd_cfg_reg;
      `EAL_A_DIAGADDR: misc_word = diag_addr_reg;
      `EAL_A_INDEX: misc_word = index_q_reg;
      8'h08, 8'h09, 8'h0a, 8'h0b: misc_word = msg_reg[reg_addr[1:0]];
      `EAL_A_PRESET0: misc_word = preset_reg[0];
      `EAL_A_PRESET1: misc_word = preset_reg[1];
      `EAL_A_TIME_LO: misc_word = seconds_reg[15:0];
      `EAL_A_TIME_HI: misc_word = seconds_reg[31:16];
      default: misc_word = 16'h0000;
    endcase
  end
  assign rdata_next = !reg_rd ? 16'h0000 : in_log ? log_mem[reg_addr[6:0]] :
                      in_flags ? flag_mem[reg_addr[4:0]] : misc_word;

  always_comb begin
    ptr_next = ptr_eff;
    if (log_wr && !log_full) begin
      ptr_next = ptr_eff + 5'h01;
    end
  end

  always_comb begin
    case (fpd_state_reg)
      eal_pkg::EAL_FPD_IDLE, eal_pkg::EAL_FPD_FAIL: begin
        fpd_state_next = failure_point_detector ? eal_pkg::EAL_FPD_TIME : fpd_state_reg;
      end
      eal_pkg::EAL_FPD_TIME: begin
        fpd_state_next = fpd_done ? eal_pkg::EAL_FPD_IDLE :
                         fpd_timeout ? eal_pkg::EAL_FPD_FAIL : fpd_state_reg;
      end
      default: fpd_state_next = eal_pkg::EAL_FPD_IDLE;
    endcase
  end

  // Log memory; a full log drops the oldest record and shifts the rest down.
  always_ff @(posedge sys_clk) begin
    if (log_wr) begin
      if (log_full) begin
        for (int i = 0; i < `EAL_LOG_WORDS - `EAL_REC_WORDS; i++) begin
          log_mem[i] <= log_mem[i+`EAL_REC_WORDS];
        end
      end
      log_mem[wbase] <= ev_code;
      log_mem[wbase+7'h01] <= ev_detail;
      log_mem[wbase+7'h02] <= {7'h00, ev_num};
      log_mem[wbase+7'h03] <= seconds_reg[15:0];
      log_mem[wbase+7'h04] <= seconds_reg[31:16];
    end
  end

  // Executed alarm number flags; a set in the clearing cycle survives.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 32; i++) begin
        flag_mem[i] <= 16'h0000;
      end
    end else begin
      if (err_clear) begin
        for (int i = 0; i < 32; i++) begin
          flag_mem[i] <= 16'h0000;
        end
      end
      if (alarm_any) begin
        flag_mem[ev_num[8:4]] <= (err_clear ? 16'h0000 : flag_mem[ev_num[8:4]])
                                 | (16'h0001 << ev_num[3:0]);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ptr_reg <= 5'h00;
      code_reg <= 16'h0000;
      rdata_reg <= 16'h0000;
    end else begin
      ptr_reg <= ptr_next;
      rdata_reg <= rdata_next;
      if (log_wr) begin
        code_reg <= ev_code;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      kill_reg <= 1'b0;
      retain_reg <= 1'b0;
      teach_reg <= 1'b0;
      fpd_cfg_reg <= 16'h0000;
      preset_reg[0] <= 16'h0000;
      preset_reg[1] <= 16'h0000;
    end else begin
      if (ctrl_wr) begin
        kill_reg <= reg_wdata[`EAL_CTRL_KILL];
        retain_reg <= reg_wdata[`EAL_CTRL_RETAIN];
        teach_reg <= reg_wdata[`EAL_CTRL_TEACH];
      end
      if (reg_wr && reg_addr == `EAL_A_FPDCFG) begin
        fpd_cfg_reg <= reg_wdata;
      end
      if (reg_wr && reg_addr == `EAL_A_PRESET0) begin
        preset_reg[0] <= reg_wdata;
      end
      if (reg_wr && reg_addr == `EAL_A_PRESET1) begin
        preset_reg[1] <= reg_wdata;
      end
    end
  end

  // Alarm flags, halt, output forcing and indicator.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      nf_flag_reg <= 1'b0;
      fatal_flag_reg <= 1'b0;
      halt_reg <= 1'b0;
      off_reg <= 1'b1;
      led_reg <= 1'b0;
    end else begin
      nf_flag_reg <= nf_raise || (nf_flag_reg && !nf_clear && !err_clear);
      fatal_flag_reg <= fatal_alarm_instr || (fatal_flag_reg && !err_clear);
      halt_reg <= fatal_alarm_instr || (halt_reg && !err_clear);
      off_reg <= kill_reg || (op_mode == eal_pkg::EAL_MODE_PROGRAM && !retain_reg);
      led_reg <= fatal_flag_reg || (nf_flag_reg && blink_reg);
    end
  end

  // Millisecond tick and the calendar seconds count.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_reg <= 15'h0000;
      ms_cnt_reg <= 10'h000;
      seconds_reg <= 32'h0000_0000;
      blink_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= ms_tick ? 15'h0000 : tick_cnt_reg + 15'h0001;
      if (ms_tick) begin
        ms_cnt_reg <= s_tick ? 10'h000 : ms_cnt_reg + 10'h001;
      end
      if (s_tick) begin
        seconds_reg <= seconds_reg + 32'h0000_0001;
      end
      // The indicator toggles at the middle and at the end of each second.
      if (ms_tick && (ms_cnt_reg == 10'h1f3 || s_tick)) begin
        blink_reg <= !blink_reg;
      end
    end
  end

  // Detector timing, teaching and diagnosis results.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fpd_state_reg <= eal_pkg::EAL_FPD_IDLE;
      fpd_cnt_reg <= 16'h0000;
      carry_reg <= 1'b0;
      mon_time_reg <= `EAL_MONTIME_RST;
      diag_addr_reg <= 16'h0000;
      index_q_reg <= 16'h0000;
      for (int i = 0; i < 4; i++) begin
        msg_reg[i] <= 16'h0000;
      end
    end else begin
      fpd_state_reg <= fpd_state_next;
      if (failure_point_detector && !fpd_timing) begin
        fpd_cnt_reg <= 16'h0000;
        carry_reg <= 1'b0;
      end else if (fpd_timing && ms_tick && fpd_cnt_reg != 16'hffff) begin
        fpd_cnt_reg <= fpd_cnt_reg + 16'h0001;
      end
      if (fpd_timeout) begin
        carry_reg <= 1'b1;
        if (!cfg_ascii) begin
          diag_addr_reg <= blk_addr;
          if (fpd_cfg_reg[`EAL_CFG_INDEX]) begin
            index_q_reg <= blk_addr;
          end
        end
        if (cfg_ascii || fpd_cfg_reg[`EAL_CFG_PREFIX]) begin
          msg_reg[0] <= blk_ascii[31:16];
          msg_reg[1] <= blk_ascii[15:0];
          msg_reg[2] <= preset_reg[0];
          msg_reg[3] <= preset_reg[1];
        end else begin
          msg_reg[0] <= preset_reg[0];
          msg_reg[1] <= preset_reg[1];
          msg_reg[2] <= 16'h0000;
          msg_reg[3] <= 16'h0000;
        end
      end
      if (fpd_done && teach_reg) begin
        mon_time_reg <= fpd_cnt_reg;
      end else if (mon_wr) begin
        mon_time_reg <= reg_wdata;
      end
    end
  end

  assign reg_rdata = rdata_reg;
  assign outputs_off = off_reg;
  assign program_halt = halt_reg;
  assign error_led = led_reg;
  assign carry_flag = carry_reg;
  assign index_reg = index_q_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence s_fatal_halts;
    fatal_alarm_instr ##1 (halt_reg && fatal_flag_reg);
  endsequence
  sequence s_timeout_carry;
    fpd_timeout ##1 carry_reg ##1 carry_flag;
  endsequence

  AST_PTR_SAT: assert property (ptr_reg <= LOG_RECS)
    else $error("log pointer beyond twenty");
  AST_PTR_INC: assert property (log_wr && !ptr_reset && ptr_reg < LOG_RECS |=>
    ptr_reg == $past(ptr_reg) + 5'h01)
    else $error("log pointer did not advance");
  AST_PTR_RST: assert property (ptr_reset && !log_wr |=> ptr_reg == 5'h00)
    else $error("log pointer not cleared");
  AST_SHIFT: assert property (log_wr && log_full |=>
    log_mem[0] == $past(log_mem[5]) && log_mem[95] == $past(ev_code))
    else $error("full log did not shift");
  AST_CODE: assert property (log_wr |=> code_reg == $past(ev_code))
    else $error("error code word not written");
  AST_KILL: assert property (kill_reg |=> outputs_off)
    else $error("outputs not forced off");
  AST_PROG_OFF: assert property ($changed(op_mode) && op_mode == eal_pkg::EAL_MODE_PROGRAM
    && !retain_reg |=> outputs_off)
    else $error("program mode left outputs on");
  AST_NF_FLAG: assert property (nf_raise && !fatal_alarm_instr && !halt_reg |=>
    nf_flag_reg && !program_halt)
    else $error("nonfatal flag not set");
  AST_FATAL: assert property (fatal_alarm_instr |-> s_fatal_halts)
    else $error("fatal alarm did not halt");
  AST_NUM_FLAG: assert property (nf_user |=>
    flag_mem[$past(alarm_num[8:4])][$past(alarm_num[3:0])])
    else $error("alarm number flag not set");
  AST_NF_CLR: assert property (nf_clear && !fpd_alarm |=> !nf_flag_reg)
    else $error("nonfatal alarm not cleared");
  AST_CARRY: assert property (fpd_timeout |-> s_timeout_carry)
    else $error("carry flag missing after timeout");
  AST_TEACH: assert property (fpd_done && teach_reg |=>
    mon_time_reg == $past(fpd_cnt_reg))
    else $error("teaching did not store time");
endmodule
`default_nettype wire

/* File: eal_prog_model.sv */
`timescale 1ns/1ns
`default_nettype none
module eal_prog_model (
  input wire logic sys_clk, // Clock.
  output logic [1:0] op_mode, // Operating mode.
  output logic sys_err_stb, // System error pulse.
  output logic [15:0] sys_err_code, // System error code.
  output logic [15:0] sys_err_detail, // System error details.
  output logic nonfatal_alarm_instr, // Nonfatal alarm pulse.
  output logic fatal_alarm_instr, // Fatal alarm pulse.
  output logic [8:0] alarm_num, // Alarm number.
  output logic failure_point_detector, // Detector executed.
  output logic diag_output, // Diagnostic output.
  output logic [15:0] diag_inputs, // Diagnosed inputs.
  output logic [15:0] diag_in_base // Bit address of input 0.
);
  initial begin
    op_mode = eal_pkg::EAL_MODE_PROGRAM;
    {sys_err_stb, nonfatal_alarm_instr, fatal_alarm_instr} = 3'h0;
    {sys_err_code, sys_err_detail, alarm_num} = 41'h0;
    {failure_point_detector, diag_output} = 2'h0;
    {diag_inputs, diag_in_base} = 32'h0;
  end
  task automatic mode(input logic [1:0] m);
    @(posedge sys_clk);
    op_mode <= m;
  endtask
  task automatic diag(input logic o, input logic [15:0] i, input logic [15:0] b);
    @(posedge sys_clk);
    diag_output <= o;
    diag_inputs <= i;
    diag_in_base <= b;
  endtask
  // Values beside a strobe are scrambled once it drops, so stale data cannot match.
  task automatic alarm(input logic fatal, input logic [8:0] num);
    @(posedge sys_clk);
    nonfatal_alarm_instr <= !fatal;
    fatal_alarm_instr <= fatal;
    alarm_num <= num;
    @(posedge sys_clk);
    nonfatal_alarm_instr <= 1'b0;
    fatal_alarm_instr <= 1'b0;
    alarm_num <= ~num;
  endtask
  task automatic sys_error(input logic [15:0] code, input logic [15:0] det);
    @(posedge sys_clk);
    sys_err_stb <= 1'b1;
    sys_err_code <= code;
    sys_err_detail <= det;
    @(posedge sys_clk);
    sys_err_stb <= 1'b0;
    sys_err_code <= ~code;
    sys_err_detail <= ~det;
  endtask
  task automatic exec_detector();
    @(posedge sys_clk);
    failure_point_detector <= 1'b1;
    @(posedge sys_clk);
    failure_point_detector <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: error_log_and_failure_alarm_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "eal_defines.svh"
module error_log_and_failure_alarm_tb;
  logic sys_clk = 1'b0;
  logic resetn;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, sys_err_code, sys_err_detail;
  logic reg_wr, reg_rd, sys_err_stb, nonfatal_alarm_instr, fatal_alarm_instr;
  logic [1:0] op_mode;
  logic [8:0] alarm_num;
  logic failure_point_detector, diag_output, outputs_off, program_halt;
  logic [15:0] diag_inputs, diag_in_base, index_reg;
  logic error_led, carry_flag;
  int fail_count = 0;
  int comparisons = 0;
  always #20 sys_clk = ~sys_clk;
  eal_top #(.TICK_CYCLES(4)) dut (.sys_clk(sys_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .op_mode(op_mode), .sys_err_stb(sys_err_stb),
    .sys_err_code(sys_err_code), .sys_err_detail(sys_err_detail),
    .nonfatal_alarm_instr(nonfatal_alarm_instr), .fatal_alarm_instr(fatal_alarm_instr),
    .alarm_num(alarm_num), .failure_point_detector(failure_point_detector),
    .diag_output(diag_output), .diag_inputs(diag_inputs), .diag_in_base(diag_in_base),
    .outputs_off(outputs_off), .program_halt(program_halt), .error_led(error_led),
    .carry_flag(carry_flag), .index_reg(index_reg));
  eal_prog_model pm (.sys_clk(sys_clk), .op_mode(op_mode), .sys_err_stb(sys_err_stb),
    .sys_err_code(sys_err_code), .sys_err_detail(sys_err_detail),
    .nonfatal_alarm_instr(nonfatal_alarm_instr), .fatal_alarm_instr(fatal_alarm_instr),
    .alarm_num(alarm_num), .failure_point_detector(failure_point_detector),
    .diag_output(diag_output), .diag_inputs(diag_inputs), .diag_in_base(diag_in_base));
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // The read word stands only in the cycle after the strobe, so it is taken there.
  task automatic rdc(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata & m, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    end_of_test();
  end
  initial begin
    int n;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = 26'h0;
    resetn = 1'b0;
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    cyc(1);
    chk({15'h0, outputs_off}, 16'h0001);
    chk({14'h0, program_halt, carry_flag}, 16'h0000);
    rdc(`EAL_A_MONTIME, 16'hffff, `EAL_MONTIME_RST);
    rdc(8'h40, 16'hffff, 16'h0000);
    wr(`EAL_A_CODE, 16'h1234);
    rdc(`EAL_A_CODE, 16'hffff, 16'h0000);
    $display("test reset done");
    pm.mode(eal_pkg::EAL_MODE_RUN);
    cyc(2);
    chk({15'h0, outputs_off}, 16'h0000);
    wr(`EAL_A_CTRL, 16'h0001);
    cyc(2);
    chk({15'h0, outputs_off}, 16'h0001);
    wr(`EAL_A_CTRL, 16'h0002);
    pm.mode(eal_pkg::EAL_MODE_PROGRAM);
    cyc(2);
    chk({15'h0, outputs_off}, 16'h0000);
    wr(`EAL_A_CTRL, 16'h0000);
    cyc(2);
    chk({15'h0, outputs_off}, 16'h0001);
    pm.mode(eal_pkg::EAL_MODE_MONITOR);
    $display("test outputs done");
    wr(`EAL_A_CTRL, 16'h0008);
    rdc(`EAL_A_PTR, 16'hffff, 16'h0000);
    pm.alarm(1'b0, 9'h002);
    rdc(`EAL_A_STAT, 16'h0001, 16'h0001);
    rdc(8'h20, 16'h0004, 16'h0004);
    rdc(`EAL_A_CODE, 16'hffff, 16'h1002);
    rdc(`EAL_A_PTR, 16'hffff, 16'h0001);
    rdc(8'h80, 16'hffff, 16'h1002);
    rdc(8'h81, 16'hffff, 16'h0002);
    rdc(8'h82, 16'hffff, 16'h0002);
    chk({15'h0, program_halt}, 16'h0000);
    pm.alarm(1'b0, 9'h000);
    rdc(`EAL_A_STAT, 16'h0001, 16'h0000);
    rdc(`EAL_A_PTR, 16'hffff, 16'h0001);
    $display("test nonfatal done");
    pm.alarm(1'b1, 9'h003);
    cyc(2);
    chk({14'h0, program_halt, error_led}, 16'h0003);
    rdc(`EAL_A_STAT, 16'h0002, 16'h0002);
    rdc(`EAL_A_CODE, 16'hffff, 16'h2003);
    rdc(8'h20, 16'h0008, 16'h0008);
    wr(`EAL_A_CTRL, 16'h0010);
    cyc(1);
    chk({15'h0, program_halt}, 16'h0000);
    rdc(`EAL_A_STAT, 16'h000b, 16'h0000);
    rdc(8'h20, 16'hffff, 16'h0000);
    $display("test fatal done");
    wr(`EAL_A_CTRL, 16'h0008);
    rdc(`EAL_A_PTR, 16'hffff, 16'h0000);
    for (n = 0; n < 22; n++) begin
      pm.sys_error(16'h0a00 + 16'(n), 16'h0b00 + 16'(n));
    end
    rdc(`EAL_A_PTR, 16'hffff, 16'h0014);
    rdc(8'h80, 16'hffff, 16'h0a02);
    rdc(8'h81, 16'hffff, 16'h0b02);
    rdc(8'hdf, 16'hffff, 16'h0a15);
    rdc(8'he0, 16'hffff, 16'h0b15);
    $display("test log done");
    wr(`EAL_A_MONTIME, 16'h0002);
    wr(`EAL_A_FPDCFG, 16'h0055);
    pm.diag(1'b0, 16'hfffb, 16'h0100);
    pm.exec_detector();
    cyc(5);
    chk({15'h0, carry_flag}, 16'h0000);
    for (n = 0; n < 40 && carry_flag !== 1'b1; n++) begin
      cyc(1);
    end
    chk({15'h0, carry_flag}, 16'h0001);
    cyc(2);
    rdc(`EAL_A_DIAGADDR, 16'hffff, 16'h0102);
    chk(index_reg, 16'h0102);
    rdc(`EAL_A_CODE, 16'hffff, 16'h1005);
    rdc(8'h20, 16'h0020, 16'h0020);
    rdc(`EAL_A_STAT, 16'h0001, 16'h0001);
    $display("test detector done");
    wr(`EAL_A_MONTIME, 16'h0064);
    wr(`EAL_A_CTRL, 16'h0004);
    pm.exec_detector();
    cyc(13);
    pm.diag(1'b1, 16'hffff, 16'h0100);
    cyc(3);
    chk({15'h0, carry_flag}, 16'h0000);
    rdc(`EAL_A_MONTIME, 16'hffff, 16'h0003);
    $display("test teaching done");
    wr(`EAL_A_CTRL, 16'h0000);
    wr(`EAL_A_FPDCFG, 16'h000a);
    wr(`EAL_A_PRESET0, 16'h4142);
    pm.diag(1'b0, 16'hff7f, 16'h0a30);
    pm.exec_detector();
    cyc(20);
    chk({15'h0, carry_flag}, 16'h0001);
    rdc(8'h08, 16'hffff, 16'h3041);
    rdc(8'h09, 16'hffff, 16'h3337);
    rdc(8'h0a, 16'hffff, 16'h4142);
    rdc(`EAL_A_DIAGADDR, 16'hffff, 16'h0102);
    $display("test message done");
    end_of_test();
  end
endmodule
`default_nettype wire
